/* File: hw/dwi_wiper_i2c.sv */
`default_nettype none

module dwi_wiper_i2c
  import dwi_pkg::*;
(
  input  wire logic       mclk,        // Core clock, 25 MHz
  input  wire logic       reset_n,     // Async reset, active low
  input  wire logic       linkClk,     // Bus sampling clock
  input  wire logic       sclIn,       // SCL pin level
  input  wire logic       sdaIn,       // SDA pin level
  output var  logic       sdaOut,      // SDA drive value, always low
  output var  logic       sdaOe,       // SDA pull-low enable
  input  wire logic [2:0] addrSel,     // addr_select_2..0 pins
  input  wire logic       supplyLow,   // Supply-low detector output
  output var  logic [7:0] wiper0,      // Channel 0 tap position
  output var  logic [7:0] wiper1,      // Channel 1 tap position
  output var  logic       shutdownAct  // Shutdown to both arrays
);

  dwi_link_t lr;
  dwi_link_t ln;
  dwi_core_t cr;
  dwi_core_t cn;

  logic lrstS1;
  logic lrstS2;

  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic ackSeen;
  logic idMatch;
  logic wrEdge;
  logic rdEdge;

  function automatic logic [7:0] nextPtr(input logic [7:0] p);
    logic [7:0] q;
    q = p;
    if (p == REG_WIPER0) begin
      q = REG_WIPER1;
    end else if (p == REG_WIPER1) begin
      q = REG_WIPER0;
    end
    return q;
  endfunction

  function automatic logic [7:0] readMux(input logic [7:0] a,
                                         input dwi_core_t c);
    logic [7:0] v;
    v = 8'h00;
    if (a == REG_WIPER0) begin
      v = c.wiperPositionCh0;
    end else if (a == REG_WIPER1) begin
      v = c.wiperPositionCh1;
    end else if (a == REG_ACCESS) begin
      v[SHUTDOWN_BIT] = c.shutdownN;                     // [R5]
    end
    return v;
  endfunction

  // Link reset: asserted at once, released on linkClk so the bus
  // engine stays deaf to any START while power comes up
  always_ff @(posedge linkClk or negedge reset_n) begin
    if (!reset_n) begin
      lrstS1 <= 1'b0;
      lrstS2 <= 1'b0;
    end else begin
      lrstS1 <= 1'b1;
      lrstS2 <= lrstS1;                                  // [R12]
    end
  end

  assign sclRise   = lr.sclS2 & ~lr.sclD;
  assign sclFall   = ~lr.sclS2 & lr.sclD;
  assign startSeen = lr.sclS2 & lr.sclD & lr.sdaD & ~lr.sdaS2;
  assign stopSeen  = lr.sclS2 & lr.sclD & ~lr.sdaD & lr.sdaS2;
  assign ackSeen   = lr.ackS2 ^ lr.ackD;
  assign idMatch   = (lr.shifter[7:4] == ID_PREFIX) &&
                     (lr.shifter[3:1] == lr.selS2);      // [R17]

  always_comb begin
    ln = lr;
    ln.sclS1 = sclIn;
    ln.sclS2 = lr.sclS1;
    ln.sclD  = lr.sclS2;
    ln.sdaS1 = sdaIn;
    ln.sdaS2 = lr.sdaS1;
    ln.sdaD  = lr.sdaS2;
    ln.selS1 = addrSel;
    ln.selS2 = lr.selS1;
    ln.ackS1 = cr.ackTgl;
    ln.ackS2 = lr.ackS1;
    ln.ackD  = lr.ackS2;
    ln.sdaLvl = 1'b0;
    if (startSeen) begin
      // Also covers a repeated START inside a transaction
      ln.st     = LkId;                                  // [R12] [R20]
      ln.bitCnt = 4'h0;
      ln.sdaOe  = 1'b0;
      ln.txWait = 1'b0;
      ln.txLoad = 1'b0;
    end else if (stopSeen) begin
      ln.st     = LkIdle;                                // [R13]
      ln.bitCnt = 4'h0;
      ln.sdaOe  = 1'b0;
      ln.txWait = 1'b0;
      ln.txLoad = 1'b0;
    end else begin
      unique case (lr.st)
        LkIdle: begin
          ln.sdaOe = 1'b0;                               // [R11]
        end
        LkId, LkAdr, LkWdat: begin
          if (sclRise) begin
            if (lr.bitCnt != BIT_LAST) begin
              ln.shifter = {lr.shifter[6:0], lr.sdaS2};  // [R9]
            end
            if (lr.bitCnt == BIT_LAST && lr.st == LkWdat) begin
              // Commit on the ninth rising edge of the data byte
              ln.wrTgl    = ~lr.wrTgl;                   // [R18]
              ln.req.addr = lr.ptr;
              ln.req.data = lr.shifter;
              ln.ptr      = nextPtr(lr.ptr);             // [R19] [R21]
            end
            ln.bitCnt = lr.bitCnt + 4'h1;
          end else if (sclFall && lr.bitCnt == BIT_LAST) begin
            if (lr.st == LkId && !idMatch) begin
              ln.st = LkIdle;                            // [R17]
            end else begin
              ln.sdaOe = 1'b1;                           // [R14] [R15]
            end
          end else if (sclFall && lr.bitCnt == BIT_ACK) begin
            ln.sdaOe  = 1'b0;                            // [R14]
            ln.bitCnt = 4'h0;
            if (lr.st == LkId) begin
              if (lr.shifter[0]) begin
                ln.st       = LkRdat;                    // [R20]
                ln.rdTgl    = ~lr.rdTgl;
                ln.req.addr = lr.ptr;
                ln.ptr      = nextPtr(lr.ptr);           // [R21]
                ln.txWait   = 1'b1;
              end else begin
                ln.st = LkAdr;
              end
            end else if (lr.st == LkAdr) begin
              ln.ptr = lr.shifter;
              ln.st  = LkWdat;
            end
          end
        end
        LkRdat: begin
          if (ackSeen && lr.txWait) begin
            ln.shifter = cr.rdData;
            ln.txWait  = 1'b0;
            ln.txLoad  = 1'b1;
            ln.bitCnt  = 4'h0;
          end else if (lr.txLoad) begin
            // Data may arrive with SCL high; hold it until SCL is low
            if (!lr.sclS2) begin
              ln.sdaOe  = ~lr.shifter[7];                // [R9] [R10]
              ln.txLoad = 1'b0;
            end
          end else if (sclRise) begin
            if (lr.bitCnt == BIT_LAST) begin
              if (lr.sdaS2) begin
                ln.st = LkIdle;                          // [R16] [R20]
              end else begin
                ln.rdTgl    = ~lr.rdTgl;                 // [R16]
                ln.req.addr = lr.ptr;
                ln.ptr      = nextPtr(lr.ptr);           // [R21]
                ln.txWait   = 1'b1;
                ln.bitCnt   = 4'h0;
              end
            end else if (!lr.txWait) begin
              ln.bitCnt = lr.bitCnt + 4'h1;
            end
          end else if (sclFall && lr.bitCnt != 4'h0) begin
            if (lr.bitCnt == BIT_LAST) begin
              ln.sdaOe = 1'b0;                           // [R14]
            end else begin
              ln.shifter = {lr.shifter[6:0], 1'b0};
              ln.sdaOe   = ~lr.shifter[6];               // [R10]
            end
          end
        end
        default: begin
          ln.st = LkIdle;
        end
      endcase
    end
  end

  always_ff @(posedge linkClk or negedge lrstS2) begin
    if (!lrstS2) begin
      lr       <= '0;                                    // [R11]
      // Pin samples start at the bus idle level, so leaving reset
      // cannot look like an SCL or SDA edge
      lr.sclS1 <= 1'b1;
      lr.sclS2 <= 1'b1;
      lr.sclD  <= 1'b1;
      lr.sdaS1 <= 1'b1;
      lr.sdaS2 <= 1'b1;
      lr.sdaD  <= 1'b1;
    end else begin
      lr <= ln;
    end
  end

  assign wrEdge = cr.wrS2 ^ cr.wrD;
  assign rdEdge = cr.rdS2 ^ cr.rdD;

  // Request address and data are held by the link side until the
  // next toggle, so they are stable when the synced edge is seen
  always_comb begin
    cn = cr;
    cn.wrS1  = lr.wrTgl;
    cn.wrS2  = cr.wrS1;
    cn.wrD   = cr.wrS2;
    cn.rdS1  = lr.rdTgl;
    cn.rdS2  = cr.rdS1;
    cn.rdD   = cr.rdS2;
    cn.lowS1 = supplyLow;
    cn.lowS2 = cr.lowS1;
    if (wrEdge) begin
      if (lr.req.addr == REG_WIPER0) begin
        cn.wiperPositionCh0 = lr.req.data;               // [R1] [R4]
      end else if (lr.req.addr == REG_WIPER1) begin
        cn.wiperPositionCh1 = lr.req.data;               // [R1] [R4]
      end else if (lr.req.addr == REG_ACCESS) begin
        cn.shutdownN = lr.req.data[SHUTDOWN_BIT];        // [R5] [R22]
      end
    end
    if (rdEdge) begin
      cn.rdData = readMux(lr.req.addr, cr);              // [R4]
      cn.ackTgl = ~cr.ackTgl;
    end
    // Detector output must persist before it counts as a real dip
    if (!cr.shutdownN && cr.lowS2) begin
      if (cr.lowCnt != LOW_CNT_DONE) begin
        cn.lowCnt = cr.lowCnt + 3'h1;
      end
    end else begin
      cn.lowCnt = 3'h0;
    end
    if (cr.lowCnt == LOW_CNT_DONE) begin
      cn.wiperPositionCh0 = WIPER_RESET;                 // [R8]
      cn.wiperPositionCh1 = WIPER_RESET;                 // [R8]
    end
    // Wiper registers are left alone here, so exit restores them
    cn.shutdownAct = ~cr.shutdownN;                      // [R6] [R7]
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cr                  <= '0;
      cr.wiperPositionCh0 <= WIPER_RESET;                // [R3]
      cr.wiperPositionCh1 <= WIPER_RESET;                // [R3]
      cr.shutdownN        <= ACCESS_RESET[SHUTDOWN_BIT];
    end else begin
      cr <= cn;
    end
  end

  // Code goes straight to the tap decoder: 00h low end, FFh high end
  assign wiper0      = cr.wiperPositionCh0;              // [R2]
  assign wiper1      = cr.wiperPositionCh1;              // [R2]
  assign shutdownAct = cr.shutdownAct;
  assign sdaOe       = lr.sdaOe;
  assign sdaOut      = lr.sdaLvl;

endmodule

`default_nettype wire

/* File: hw/dwi_pkg.sv */
// What this block does
// R1: Each of two channels keeps its wiper position in a volatile 8-bit register.
// R2: Position 00h is nearest the low terminal, FFh nearest high, monotonic between.
// R3: At power-up both wiper registers load 80h, mid-scale.
// R4: Address 0 is channel 0 wiper, 1 is channel 1, 10h access control.
// R5: Access control bit 6 is active-low shutdown for both channels; others zero.
// R6: Shutdown control to the array is asserted while shutdown_n is 0.
// R7: Shutdown leaves wiper registers untouched; leaving it restores stored positions.
// R8: Supply-low glitch during shutdown resets both wipers to mid-scale.
// R9: Bytes on the bus travel most significant bit first.
// R10: SDA changes only while SCL is low, except START and STOP.
// R11: After power-up the SDA driver stays released.
// R12: Nothing is answered before START; START during power-up is ignored.
// R13: STOP returns the bus interface to idle.
// R14: Transmitter releases SDA after eight bits; receiver pulls low on ninth.
// R15: Device acknowledges valid ID, address byte and every written data byte.
// R16: Master acknowledges read bytes except the last one.
// R17: ID byte is 1010, then address-select pins, then read/write bit.
// R18: Write is ID, address, data; register updates at the data ninth clock.
// R19: Further data bytes before STOP write the following wiper channels.
// R20: Read is write ID, address, repeated START, read ID, data until NACK.
// R21: Pointer advances after each data byte, channel 0 wiper to channel 1.
// R22: Unmapped writes change nothing; only shutdown_n stores in access control.
`default_nettype none

package dwi_pkg;

  localparam logic [7:0] REG_WIPER0   = 8'h00;
  localparam logic [7:0] REG_WIPER1   = 8'h01;
  localparam logic [7:0] REG_ACCESS   = 8'h10;
  localparam logic [7:0] WIPER_RESET  = 8'h80;
  localparam logic [7:0] ACCESS_RESET = 8'h40;
  localparam int         SHUTDOWN_BIT = 6;
  localparam logic [3:0] ID_PREFIX    = 4'hA;
  localparam logic [3:0] BIT_LAST     = 4'h8;
  localparam logic [3:0] BIT_ACK      = 4'h9;

  localparam int MCLK_NS       = 40;
  localparam int LOW_GLITCH_NS = 200;
  localparam int LOW_GLITCH_CYC =
    (LOW_GLITCH_NS + MCLK_NS - 1) / MCLK_NS;
  localparam logic [2:0] LOW_CNT_DONE = 3'(LOW_GLITCH_CYC);

  typedef enum logic [2:0] {
    LkIdle,
    LkId,
    LkAdr,
    LkWdat,
    LkRdat
  } dwi_lstate_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } dwi_req_t;

  typedef struct packed {
    logic        sclS1;
    logic        sclS2;
    logic        sclD;
    logic        sdaS1;
    logic        sdaS2;
    logic        sdaD;
    logic [2:0]  selS1;
    logic [2:0]  selS2;
    logic        ackS1;
    logic        ackS2;
    logic        ackD;
    dwi_lstate_t st;
    logic [3:0]  bitCnt;
    logic [7:0]  shifter;
    logic [7:0]  ptr;
    logic        txWait;
    logic        txLoad;
    logic        wrTgl;
    logic        rdTgl;
    dwi_req_t    req;
    logic        sdaOe;
    logic        sdaLvl;
  } dwi_link_t;

  typedef struct packed {
    logic       wrS1;
    logic       wrS2;
    logic       wrD;
    logic       rdS1;
    logic       rdS2;
    logic       rdD;
    logic       ackTgl;
    logic [7:0] rdData;
    logic [7:0] wiperPositionCh0;
    logic [7:0] wiperPositionCh1;
    logic       shutdownN;
    logic       shutdownAct;
    logic       lowS1;
    logic       lowS2;
    logic [2:0] lowCnt;
  } dwi_core_t;

endpackage

`default_nettype wire

/* File: testbench/dwi_asserts.sv */
`default_nettype none

module dwi_asserts
  import dwi_pkg::*;
(
  input wire logic       mclk,        // Core clock
  input wire logic       reset_n,     // Async reset, active low
  input wire logic       linkClk,     // Bus sampling clock
  input wire logic       sclIn,       // SCL level
  input wire logic       sdaOut,      // SDA drive value
  input wire logic       sdaOe,       // SDA pull-low enable
  input wire logic       supplyLow,   // Supply-low flag
  input wire logic [7:0] wiper0,      // Channel 0 tap
  input wire logic [7:0] wiper1,      // Channel 1 tap
  input wire logic       shutdownAct  // Shutdown to arrays
);
  timeunit 1ns;
  timeprecision 1ps;

  rst_mid_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(reset_n) |-> wiper0 == WIPER_RESET && wiper1 == WIPER_RESET
      && !shutdownAct)
    else $error("wipers not mid-scale after reset");
  oe_idle_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(reset_n) |-> !sdaOe [*4])
    else $error("SDA driven after reset");
  sda_low_a: assert property (@(posedge mclk) disable iff (!reset_n)
    sdaOut == 1'b0)
    else $error("SDA drive value not low");
  // Held long enough to pass the sync and the filter count
  glitch_mid_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (shutdownAct && supplyLow) [*8] |-> ##2
      (wiper0 == WIPER_RESET && wiper1 == WIPER_RESET))
    else $error("supply glitch did not recentre wipers");
  shut_keep_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(shutdownAct) |-> $stable(wiper0) && $stable(wiper1))
    else $error("wipers moved entering shutdown");
  shut_exit_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $fell(shutdownAct) |-> $stable(wiper0) && $stable(wiper1))
    else $error("wipers moved leaving shutdown");
  oe_rise_a: assert property (@(posedge linkClk)
    disable iff (!reset_n) $rose(sdaOe) |-> !sclIn)
    else $error("SDA pulled while SCL high");
  oe_fall_a: assert property (@(posedge linkClk)
    disable iff (!reset_n) $fell(sdaOe) |-> !sclIn)
    else $error("SDA released while SCL high");
endmodule

bind dwi_wiper_i2c dwi_asserts u_chk (.mclk(mclk), .reset_n(reset_n),
  .linkClk(linkClk), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .supplyLow(supplyLow), .wiper0(wiper0), .wiper1(wiper1),
  .shutdownAct(shutdownAct));

`default_nettype wire

/* File: testbench/dwi_i2c_master.sv */
`default_nettype none

module dwi_i2c_master (
  input  wire logic linkClk, // Bus sampling clock
  input  wire logic sda,     // Resolved SDA level
  output var  logic scl,     // SCL level driven
  output var  logic sdaRel   // 1 releases SDA, 0 pulls low
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl = 1'b1;
    sdaRel = 1'b1;
  end

  task automatic tk(input int n);
    repeat (n) @(negedge linkClk);
  endtask

  // Data moves mid-low, sampled mid-high
  task automatic bitx(input logic b, output logic s);
    sdaRel = b;
    tk(4);
    scl = 1'b1;
    tk(3);
    s = sda;
    tk(3);
    scl = 1'b0;
    tk(4);
  endtask

  task automatic start();
    sdaRel = 1'b1;
    tk(4);
    scl = 1'b1;
    tk(6);
    sdaRel = 1'b0;
    tk(6);
    scl = 1'b0;
    tk(4);
  endtask

  task automatic stop();
    sdaRel = 1'b0;
    tk(4);
    scl = 1'b1;
    tk(6);
    sdaRel = 1'b1;
    tk(6);
  endtask

  task automatic wrB(input logic [7:0] b, output logic ak);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(b[i], s);
    bitx(1'b1, ak);
  endtask

  task automatic rdB(input logic last, output logic [7:0] d);
    logic s;
    // Device needs SCL held low while it fetches the byte
    tk(30);
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, s);
      d[i] = s;
    end
    bitx(last, s);
  endtask
endmodule

`default_nettype wire

/* File: testbench/testbench.sv */
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dwi_pkg::*;

  logic       mclk = 0, linkClk = 0, reset_n = 0, supplyLow = 0;
  logic [2:0] addrSel = 0;
  logic       sclM, sdaRel, sdaOut, sdaOe, shutdownAct, ak;
  logic [7:0] wiper0, wiper1, obs, rd0, d0, d1;
  logic [7:0] expQ[$];
  int         errors = 0;
  int         total_checks = 0;
  event       got;
  // Pull-up: low only when someone pulls
  wire        sda = sdaRel & (sdaOut | ~sdaOe);

  always #20 mclk = ~mclk;
  initial #7 forever #32 linkClk = ~linkClk;

  dwi_wiper_i2c u_dut (.mclk(mclk), .reset_n(reset_n), .linkClk(linkClk),
    .sclIn(sclM), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .addrSel(addrSel), .supplyLow(supplyLow), .wiper0(wiper0),
    .wiper1(wiper1), .shutdownAct(shutdownAct));
  dwi_i2c_master u_mst (.linkClk(linkClk), .sda(sda), .scl(sclM),
    .sdaRel(sdaRel));

  task automatic print_verdict();
    if (errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] e, input logic [7:0] v);
    expQ.push_back(e);
    obs = v;
    ->got;
    #1;
  endtask

  always @(got) begin
    total_checks++;
    if (expQ.size() == 0 || obs !== expQ.pop_front()) begin
      errors++;
      $display("[FAIL] %0t ns: unexpected %h", $time, obs);
    end
  end

  task automatic hdr(input logic [7:0] a);
    u_mst.start();
    u_mst.wrB({ID_PREFIX, addrSel, 1'b0}, ak);
    chk(8'h00, {7'h0, ak});
    u_mst.wrB(a, ak);
    chk(8'h00, {7'h0, ak});
  endtask

  task automatic wr(input logic [7:0] a, x0, x1, input int n);
    hdr(a);
    u_mst.wrB(x0, ak);
    chk(8'h00, {7'h0, ak});
    if (n > 1) begin
      u_mst.wrB(x1, ak);
      chk(8'h00, {7'h0, ak});
    end
    u_mst.stop();
  endtask

  task automatic rd(input logic [7:0] a, e0, e1, input int n);
    hdr(a);
    u_mst.start();
    u_mst.wrB({ID_PREFIX, addrSel, 1'b1}, ak);
    chk(8'h00, {7'h0, ak});
    u_mst.rdB(n == 1, rd0);
    chk(e0, rd0);
    if (n > 1) begin
      u_mst.rdB(1'b1, rd0);
      chk(e1, rd0);
    end
    u_mst.stop();
  endtask

  task automatic pulse();
    @(negedge mclk);
    supplyLow = 1'b1;
    repeat (12) @(negedge mclk);
    supplyLow = 1'b0;
    repeat (4) @(negedge mclk);
  endtask

  initial begin
    #2000000;
    errors++;
    print_verdict();
  end

  initial begin
    void'($urandom(45));
    addrSel = 3'($urandom);
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    repeat (6) @(negedge mclk);
    reset_n = 1'b1;
    repeat (20) @(negedge mclk);
    chk(WIPER_RESET, wiper0);
    chk(WIPER_RESET, wiper1);
    rd(REG_WIPER0, WIPER_RESET, WIPER_RESET, 2);
    rd(REG_ACCESS, ACCESS_RESET, 8'h00, 1);
    wr(REG_WIPER0, d0, d1, 2);
    chk(d0, wiper0);
    chk(d1, wiper1);
    rd(REG_WIPER0, d0, d1, 2);
    wr(REG_WIPER1, 8'hFF, 8'h00, 1);
    chk(8'hFF, wiper1);
    // Sequential read from channel 1 wraps the pointer back to channel 0
    rd(REG_WIPER1, 8'hFF, d0, 2);
    u_mst.start();
    u_mst.wrB({ID_PREFIX, addrSel ^ 3'h1, 1'b0}, ak);
    chk(8'h01, {7'h0, ak});
    u_mst.stop();
    wr(8'h05, 8'h00, 8'h00, 1);
    chk(d0, wiper0);
    chk(8'hFF, wiper1);
    rd(8'h05, 8'h00, 8'h00, 1);
    pulse();
    chk(d0, wiper0);
    wr(REG_ACCESS, 8'hFF, 8'h00, 1);
    rd(REG_ACCESS, ACCESS_RESET, 8'h00, 1);
    wr(REG_ACCESS, 8'h00, 8'h00, 1);
    repeat (8) @(negedge mclk);
    chk(8'h01, {7'h0, shutdownAct});
    chk(d0, wiper0);
    pulse();
    chk(WIPER_RESET, wiper0);
    chk(WIPER_RESET, wiper1);
    wr(REG_ACCESS, ACCESS_RESET, 8'h00, 1);
    repeat (8) @(negedge mclk);
    chk(8'h00, {7'h0, shutdownAct});
    print_verdict();
  end
endmodule

`default_nettype wire
